// ### common/cbie_defines.svh
`ifndef CBIE_DEFINES_SVH
`define CBIE_DEFINES_SVH
// What this block does
// - absolute jump reaches whole 2-Mbyte space
// - jump loads 20-bit target into PC 20:1
// - jump is two words, always two cycles
// - jump words: EF/target low, F/target high
// - jump phases: decode, read, write PC; nop cycle
// - increment adds one, updates C DC N OV Z
// - bank bit 0 access bank, 1 bank register
// - skipped two-word instruction gives two nop cycles
// - decrement nonzero result discards next instruction
// - destination bit: 0 accumulator, 1 data register

// ==========================================
// register offsets
`define CBIE_OFF_CTRL 8'h00
`define CBIE_OFF_WREG 8'h04
`define CBIE_OFF_STATUS 8'h08
`define CBIE_OFF_BANK 8'h0C
`define CBIE_OFF_PC 8'h10
`define CBIE_CTRL_RUN_BIT 0
// ==========================================
// reset values
`define CBIE_RST_RUN 1'b0
`define CBIE_RST_WREG 8'h00
`define CBIE_RST_STATUS 5'h00
`define CBIE_RST_PC 21'h000000
// ==========================================
// instruction encoding
`define CBIE_JMP1_TOP 8'hEF
`define CBIE_JMP2_TOP 4'hF
`define CBIE_INC_OP 6'h0A
`define CBIE_DSNZ_OP 6'h13
`define CBIE_DEST_BIT 9
`define CBIE_BANKSEL_BIT 8
`define CBIE_ACC_SPLIT 8'h60
// ==========================================
// timing: four phases per instruction cycle
`define CBIE_Q_LAST 2'h3
`define CBIE_PC_STEP 21'h000002
`endif

// ### common/cbie_pkg.sv
`default_nettype none
`include "cbie_defines.svh"
package cbie_pkg;
    typedef enum logic [2:0] {
        ST_EXEC = 3'b001,
        ST_FLUSH = 3'b010,
        ST_FLUSH2 = 3'b100
    } cbie_state_t;

    typedef enum logic [3:0] {
        OP_NOP = 4'b0001,
        OP_JMP = 4'b0010,
        OP_INC = 4'b0100,
        OP_DSNZ = 4'b1000
    } cbie_op_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } cbie_apb_req_t;

    typedef struct packed {
        cbie_op_t op;
        logic dest_f;
        logic use_bank;
        logic [7:0] fadr;
    } cbie_dec_t;

    typedef struct packed {
        logic n;
        logic ov;
        logic z;
        logic dc;
        logic c;
    } cbie_flags_t;
endpackage
`default_nettype wire

// ### hdl/cbie_data_ram.sv
`timescale 1ns/1ns
`default_nettype none
module cbie_data_ram #(
    parameter int AW = 12,
    parameter int DW = 8
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [AW-1:0] addr,
    output logic [DW-1:0] rd_data,
    input wire logic we,
    input wire logic [DW-1:0] wr_data
);
    logic [DW-1:0] mem [0:(1<<AW)-1];
    logic [DW-1:0] rd_data_r;
    logic [DW-1:0] rd_data_nxt;

    // registered read: a write in the same cycle returns the old byte
    always_comb begin
        rd_data_nxt = mem[addr];
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rd_data_r <= '0;
        end else begin
            rd_data_r <= rd_data_nxt;
        end
    end

    // storage clears while reset is held, so programs start from known bytes
    always_ff @(posedge core_clk) begin
        if (rst) begin
            for (int i = 0; i < (1 << AW); i++) begin
                mem[i] <= '0;
            end
        end else if (we) begin
            mem[addr] <= wr_data;
        end
    end

    assign rd_data = rd_data_r;
endmodule
`default_nettype wire

// ### hdl/cbie_exec_core.sv
// Local design decisions: the placing of the registers and the APB slave port.
`timescale 1ns/1ns
`default_nettype none
module cbie_exec_core
    import cbie_pkg::*;
#(
    parameter int PC_W = 21,
    parameter int BANK_W = 4
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire cbie_apb_req_t apb_req,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic [PC_W-1:0] prog_addr,
    input wire logic [15:0] prog_data
);
    localparam int DA_W = BANK_W + 8;

    // ==========================================
    // decoding
    function automatic logic is_jump1(input logic [15:0] w);
        return w[15:8] == `CBIE_JMP1_TOP;
    endfunction

    function automatic logic reg_hit(input logic [7:0] a);
        return (a == `CBIE_OFF_CTRL) || (a == `CBIE_OFF_WREG) || (a == `CBIE_OFF_STATUS)
            || (a == `CBIE_OFF_BANK) || (a == `CBIE_OFF_PC);
    endfunction

    function automatic cbie_dec_t decode_word(input logic [15:0] w);
        cbie_dec_t d;
        d.op = OP_NOP;
        d.dest_f = w[`CBIE_DEST_BIT];
        d.use_bank = w[`CBIE_BANKSEL_BIT];
        d.fadr = w[7:0];
        if (is_jump1(w)) begin
            d.op = OP_JMP;
        end else if (w[15:10] == `CBIE_INC_OP) begin
            d.op = OP_INC;
        end else if (w[15:10] == `CBIE_DSNZ_OP) begin
            d.op = OP_DSNZ;
        end
        return d;
    endfunction

    // ==========================================
    // state
    logic [1:0] q_r, q_nxt;
    cbie_state_t state_r, state_nxt;
    logic [15:0] ir_r, ir_nxt;
    cbie_dec_t dec_r, dec_nxt;
    logic [7:0] res_r, res_nxt;
    cbie_flags_t flags_r, flags_nxt;
    logic [7:0] w_r, w_nxt;
    logic [BANK_W-1:0] bank_r, bank_nxt;
    logic [PC_W-1:0] pc_r, pc_nxt;
    logic run_r, run_nxt;
    logic [31:0] prdata_r, prdata_nxt;

    logic apb_wr;
    logic exec_q4;
    logic rf_we;
    logic [DA_W-1:0] rf_addr;
    logic [7:0] rf_rdata;
    logic [PC_W-1:0] jmp_target;

    assign apb_wr = apb_req.psel && apb_req.penable && apb_req.pwrite && reg_hit(apb_req.paddr);
    assign exec_q4 = run_r && (state_r == ST_EXEC) && (q_r == `CBIE_Q_LAST);
    // 20-bit target lands on PC 20:1, bit 0 forced low
    assign jmp_target = PC_W'({prog_data[11:0], dec_r.fadr, 1'b0});

    // access bank: low part maps to bank 0, the rest to the top bank
    always_comb begin
        if (dec_r.use_bank) begin
            rf_addr = {bank_r, dec_r.fadr};
        end else if (dec_r.fadr < `CBIE_ACC_SPLIT) begin
            rf_addr = {{BANK_W{1'b0}}, dec_r.fadr};
        end else begin
            rf_addr = {{BANK_W{1'b1}}, dec_r.fadr};
        end
    end

    assign rf_we = exec_q4 && ((dec_r.op == OP_INC) || (dec_r.op == OP_DSNZ))
        && dec_r.dest_f;

    cbie_data_ram #(
        .AW(DA_W),
        .DW(8)
    ) u_ram (
        .core_clk(core_clk),
        .rst(rst),
        .addr(rf_addr),
        .rd_data(rf_rdata),
        .we(rf_we),
        .wr_data(res_r)
    );

    // ==========================================
    // execution sequencer
    always_comb begin
        q_nxt = q_r;
        state_nxt = state_r;
        ir_nxt = ir_r;
        dec_nxt = dec_r;
        res_nxt = res_r;
        flags_nxt = flags_r;
        w_nxt = w_r;
        bank_nxt = bank_r;
        pc_nxt = pc_r;
        run_nxt = run_r;
        // software first, so a core update in the same cycle wins
        if (apb_wr) begin
            case (apb_req.paddr)
                `CBIE_OFF_CTRL: run_nxt = apb_req.pwdata[`CBIE_CTRL_RUN_BIT];
                `CBIE_OFF_WREG: w_nxt = apb_req.pwdata[7:0];
                `CBIE_OFF_STATUS: flags_nxt = apb_req.pwdata[4:0];
                `CBIE_OFF_BANK: bank_nxt = apb_req.pwdata[BANK_W-1:0];
                `CBIE_OFF_PC: begin
                    // the program counter is only loadable while halted
                    if (!run_r) begin
                        pc_nxt = {apb_req.pwdata[PC_W-1:1], 1'b0};
                    end
                end
                default: begin
                end
            endcase
        end
        if (run_r) begin
            q_nxt = q_r + 2'h1;
            case (state_r)
                ST_EXEC: begin
                    if (q_r == 2'h0) begin
                        dec_nxt = decode_word(ir_r);
                    end
                    if (q_r == 2'h2) begin
                        res_nxt = (dec_r.op == OP_INC) ? rf_rdata + 8'h01 : rf_rdata - 8'h01;
                    end
                    if (q_r == `CBIE_Q_LAST) begin
                        ir_nxt = prog_data;
                        pc_nxt = pc_r + PC_W'(`CBIE_PC_STEP);
                        if (((dec_r.op == OP_INC) || (dec_r.op == OP_DSNZ)) && !dec_r.dest_f) begin
                            w_nxt = res_r;
                        end
                        case (dec_r.op)
                            OP_JMP: begin
                                // second word read in the last phase, fetch restarts at target
                                if (prog_data[15:12] == `CBIE_JMP2_TOP) begin
                                    ir_nxt = ir_r;
                                    pc_nxt = jmp_target;
                                    state_nxt = ST_FLUSH;
                                end
                            end
                            OP_INC: begin
                                // operand is still on the read port during this phase
                                flags_nxt.c = rf_rdata == 8'hFF;
                                flags_nxt.dc = rf_rdata[3:0] == 4'hF;
                                flags_nxt.ov = rf_rdata == 8'h7F;
                                flags_nxt.z = res_r == 8'h00;
                                flags_nxt.n = res_r[7];
                            end
                            OP_DSNZ: begin
                                if (res_r != 8'h00) begin
                                    // the word just fetched is dropped; a two-word one costs two
                                    state_nxt = is_jump1(prog_data) ? ST_FLUSH2 : ST_FLUSH;
                                end
                            end
                            default: begin
                            end
                        endcase
                    end
                end
                ST_FLUSH, ST_FLUSH2: begin
                    if (q_r == `CBIE_Q_LAST) begin
                        ir_nxt = prog_data;
                        pc_nxt = pc_r + PC_W'(`CBIE_PC_STEP);
                        state_nxt = (state_r == ST_FLUSH2) ? ST_FLUSH : ST_EXEC;
                    end
                end
                default: state_nxt = ST_FLUSH;
            endcase
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            q_r <= 2'h0;
            state_r <= ST_FLUSH;
            ir_r <= 16'h0000;
            dec_r <= '{op: OP_NOP, dest_f: 1'b0, use_bank: 1'b0, fadr: 8'h00};
            res_r <= 8'h00;
            flags_r <= `CBIE_RST_STATUS;
            w_r <= `CBIE_RST_WREG;
            bank_r <= '0;
            pc_r <= PC_W'(`CBIE_RST_PC);
            run_r <= `CBIE_RST_RUN;
        end else begin
            q_r <= q_nxt;
            state_r <= state_nxt;
            ir_r <= ir_nxt;
            dec_r <= dec_nxt;
            res_r <= res_nxt;
            flags_r <= flags_nxt;
            w_r <= w_nxt;
            bank_r <= bank_nxt;
            pc_r <= pc_nxt;
            run_r <= run_nxt;
        end
    end

    // ==========================================
    // apb read path: data captured in the setup cycle so it leaves a flop
    always_comb begin
        prdata_nxt = prdata_r;
        if (apb_req.psel && !apb_req.penable && !apb_req.pwrite) begin
            case (apb_req.paddr)
                `CBIE_OFF_CTRL: prdata_nxt = {31'h00000000, run_r};
                `CBIE_OFF_WREG: prdata_nxt = {24'h000000, w_r};
                `CBIE_OFF_STATUS: prdata_nxt = {27'h0000000, flags_r};
                `CBIE_OFF_BANK: prdata_nxt = {{(32-BANK_W){1'b0}}, bank_r};
                `CBIE_OFF_PC: prdata_nxt = {{(32-PC_W){1'b0}}, pc_r};
                default: prdata_nxt = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            prdata_r <= 32'h00000000;
        end else begin
            prdata_r <= prdata_nxt;
        end
    end

    assign prdata = prdata_r;
    assign pready = 1'b1;
    assign pslverr = apb_req.psel && apb_req.penable && !reg_hit(apb_req.paddr);
    assign prog_addr = pc_r;

    // ==========================================
    // checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    sequence s_jmp_fire;
        exec_q4 && (dec_r.op == OP_JMP) && (prog_data[15:12] == `CBIE_JMP2_TOP);
    endsequence
    sequence s_nop_cycle;
        (state_r == ST_FLUSH && run_r) [*4];
    endsequence
    sequence s_skip_fire;
        exec_q4 && (dec_r.op == OP_DSNZ) && (res_r != 8'h00);
    endsequence

    jmp_pc_load_a: assert property (s_jmp_fire |=> pc_r == $past(jmp_target))
        else $error("jump did not load target into pc");
    pc_align_a: assert property (pc_r[0] == 1'b0)
        else $error("pc bit 0 not zero");
    jmp_two_cyc_a: assert property (s_jmp_fire ##1 s_nop_cycle |=> state_r == ST_EXEC)
        else $error("jump not exactly two cycles");
    jmp_no_fetch_a: assert property (s_jmp_fire |=> ir_r == $past(ir_r))
        else $error("jump cycle fetched an instruction");
    jmp_decode_a: assert property (run_r && state_r == ST_EXEC && q_r == 2'h0
        && ir_r[15:8] == `CBIE_JMP1_TOP |=> dec_r.op == OP_JMP)
        else $error("jump first word not decoded");
    inc_result_a: assert property (exec_q4 && dec_r.op == OP_INC && !dec_r.dest_f
        |=> w_r == $past(rf_rdata) + 8'h01 && flags_r.z == (w_r == 8'h00))
        else $error("increment result or zero flag wrong");
    inc_carry_a: assert property (exec_q4 && dec_r.op == OP_INC
        |=> flags_r.c == ($past(rf_rdata) == 8'hFF))
        else $error("increment carry wrong");
    dest_sel_a: assert property (exec_q4 && dec_r.op != OP_JMP && dec_r.op != OP_NOP
        && dec_r.dest_f |-> rf_we ##1 (w_r == $past(w_r) || $past(apb_wr)))
        else $error("result not written to data register");
    bank_sel_a: assert property (run_r && state_r == ST_EXEC && q_r == 2'h1
        |-> rf_addr[DA_W-1:8] == (dec_r.use_bank ? bank_r
        : (dec_r.fadr < `CBIE_ACC_SPLIT ? '0 : '1)))
        else $error("wrong register bank");
    skip_one_a: assert property ((s_skip_fire and !is_jump1(prog_data))
        |=> state_r == ST_FLUSH)
        else $error("nonzero decrement did not skip");
    skip_two_a: assert property ((s_skip_fire and is_jump1(prog_data))
        ##1 (state_r == ST_FLUSH2 && run_r) [*4] |=> state_r == ST_FLUSH)
        else $error("two-word skip not two nop cycles");
    noskip_a: assert property (exec_q4 && dec_r.op == OP_DSNZ && res_r == 8'h00
        |=> state_r == ST_EXEC)
        else $error("zero decrement skipped");
endmodule
`default_nettype wire

// ### tb/cbie_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
`include "cbie_defines.svh"
module cbie_tb_top
    import cbie_pkg::*;
;
    typedef struct packed {
        logic [7:0] f;
        logic [7:0] v;
        logic [7:0] w;
        logic [4:0] st;
    } cbie_row_t;
    // ==========================================
    // clock, reset, design
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    cbie_apb_req_t apb_req = '0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [20:0] prog_addr;
    logic [15:0] prog_data = 16'h0000;
    logic [15:0] pmem [int];
    int pw;
    int pm_gen;
    int n_fail;
    int compares;
    int hold;
    logic running = 1'b0;
    logic held_run = 1'b0;
    logic hit_top = 1'b0;
    logic [20:0] last_addr = '0;
    logic [31:0] rd;
    logic err;
    // operand value, then W and {N,OV,Z,DC,C} after one more increment to W
    cbie_row_t rows [5] = '{
        '{8'h20, 8'hFF, 8'h00, 5'b00111},
        '{8'h21, 8'h7F, 8'h80, 5'b11010},
        '{8'h22, 8'h0F, 8'h10, 5'b00010},
        '{8'h23, 8'h00, 8'h01, 5'b00000},
        '{8'h24, 8'hFE, 8'hFF, 5'b10000}
    };

    always #25 core_clk = ~core_clk;

    cbie_exec_core #(.PC_W(21), .BANK_W(4)) DUT (
        .core_clk(core_clk),
        .rst(rst),
        .apb_req(apb_req),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .prog_addr(prog_addr),
        .prog_data(prog_data)
    );

    // pm_gen forces a refetch when the image changes under an unchanged address
    always @(prog_addr, pm_gen) begin
        prog_data = pmem.exists(int'(prog_addr[20:1])) ? pmem[int'(prog_addr[20:1])] : 16'h0000;
    end

    // ==========================================
    // checks and program building
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // only instruction cycles that began and ended while running are timed
    always @(posedge core_clk) begin
        if (!rst && prog_addr !== last_addr) begin
            chk("fetch address bit 0", 32'h0, {31'h0, prog_addr[0]});
            if (running && held_run) begin
                chk("instruction cycle clocks", 32'd4, 32'(hold));
            end
            if (prog_addr === 21'h1FFFFA) begin
                hit_top = 1'b1;
            end
            held_run = running;
            hold = 1;
            last_addr = prog_addr;
        end else begin
            hold++;
            held_run = held_run & running;
        end
    end

    function automatic logic [15:0] op_inc(input logic d, input logic a, input logic [7:0] f);
        return {`CBIE_INC_OP, d, a, f};
    endfunction

    function automatic logic [15:0] op_dsnz(input logic d, input logic a, input logic [7:0] f);
        return {`CBIE_DSNZ_OP, d, a, f};
    endfunction

    task automatic emit(input logic [15:0] w);
        pmem[pw] = w;
        pw++;
        pm_gen++;
    endtask

    task automatic new_prog();
        pmem.delete();
        pw = 0;
        pm_gen++;
    endtask

    // every program parks in a jump to itself, so the stop time does not matter
    task automatic emit_loop();
        logic [19:0] k;
        k = 20'(pw);
        emit({`CBIE_JMP1_TOP, k[7:0]});
        emit({`CBIE_JMP2_TOP, k[19:8]});
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge core_clk);
        apb_req.psel <= 1'b1;
        apb_req.penable <= 1'b0;
        apb_req.pwrite <= wr;
        apb_req.paddr <= a;
        apb_req.pwdata <= d;
        @(posedge core_clk);
        apb_req.penable <= 1'b1;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1 && n < 100);
        if (n >= 100) begin
            chk("apb ready", 32'h1, 32'h0);
        end
        rd = prdata;
        err = pslverr;
        apb_req.psel <= 1'b0;
        apb_req.penable <= 1'b0;
    endtask

    task automatic run_prog(input int cyc);
        apb(1'b1, `CBIE_OFF_PC, 32'h0);
        apb(1'b1, `CBIE_OFF_CTRL, 32'h1);
        running <= 1'b1;
        repeat (cyc * 4) @(posedge core_clk);
        running <= 1'b0;
        apb(1'b1, `CBIE_OFF_CTRL, 32'h0);
    endtask

    task automatic chk_w(input logic [7:0] exp);
        apb(1'b0, `CBIE_OFF_WREG, 32'h0);
        chk("accumulator", {24'h0, exp}, rd);
    endtask

    // ==========================================
    // main sequence
    initial begin
        logic [7:0] regs [5];
        regs = '{`CBIE_OFF_CTRL, `CBIE_OFF_WREG, `CBIE_OFF_STATUS, `CBIE_OFF_BANK, `CBIE_OFF_PC};
        repeat (8) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        chk("prog_addr after reset", 32'h0, {11'h0, prog_addr});
        foreach (regs[i]) begin
            apb(1'b0, regs[i], 32'h0);
            chk("register reset value", 32'h0, rd);
        end
        apb(1'b0, 8'h14, 32'h0);
        chk("unmapped error", 32'h1, {31'h0, err});
        chk("unmapped data", 32'h0, rd);
        // data ram clears on reset: the bench counts each byte up from zero
        foreach (rows[i]) begin
            new_prog();
            repeat (int'(rows[i].v)) emit(op_inc(1'b1, 1'b0, rows[i].f));
            emit(op_inc(1'b0, 1'b0, rows[i].f));
            emit_loop();
            run_prog(int'(rows[i].v) + 8);
            chk_w(rows[i].w);
            apb(1'b0, `CBIE_OFF_STATUS, 32'h0);
            chk("status flags", {27'h0, rows[i].st}, rd);
        end
        apb(1'b1, `CBIE_OFF_BANK, 32'h3);
        new_prog();
        emit(op_inc(1'b1, 1'b1, 8'h10));
        emit(op_inc(1'b1, 1'b1, 8'h10));
        emit(op_inc(1'b0, 1'b0, 8'h10));
        emit(op_inc(1'b1, 1'b0, 8'h70));
        emit_loop();
        run_prog(10);
        chk_w(8'h01);
        apb(1'b1, `CBIE_OFF_BANK, 32'hF);
        new_prog();
        emit(op_inc(1'b0, 1'b1, 8'h70));
        emit_loop();
        run_prog(6);
        chk_w(8'h02);
        new_prog();
        emit(op_inc(1'b1, 1'b0, 8'h40));
        emit(op_inc(1'b1, 1'b0, 8'h40));
        emit(op_dsnz(1'b1, 1'b0, 8'h40));
        emit(op_inc(1'b1, 1'b0, 8'h40));
        emit(op_inc(1'b0, 1'b0, 8'h40));
        emit_loop();
        run_prog(12);
        chk_w(8'h02);
        new_prog();
        emit(op_inc(1'b1, 1'b0, 8'h42));
        emit(op_dsnz(1'b0, 1'b0, 8'h42));
        emit(op_inc(1'b1, 1'b0, 8'h42));
        emit(op_inc(1'b0, 1'b0, 8'h42));
        emit_loop();
        run_prog(10);
        chk_w(8'h03);
        // a skipped jump must not branch to the decoy at word 16
        new_prog();
        emit(op_inc(1'b1, 1'b0, 8'h43));
        emit(op_inc(1'b1, 1'b0, 8'h43));
        emit(op_dsnz(1'b1, 1'b0, 8'h43));
        emit(16'hEF10);
        emit(16'hF000);
        emit(op_inc(1'b0, 1'b0, 8'h43));
        emit_loop();
        pw = 16;
        emit(op_inc(1'b0, 1'b0, 8'h44));
        emit_loop();
        run_prog(20);
        chk_w(8'h02);
        new_prog();
        emit(16'hEF40);
        emit(op_inc(1'b0, 1'b0, 8'h45));
        emit_loop();
        run_prog(8);
        chk_w(8'h01);
        new_prog();
        emit(16'hEFFD);
        emit(16'hFFFF);
        pw = 1048573;
        emit(op_inc(1'b0, 1'b0, 8'h46));
        emit_loop();
        hit_top = 1'b0;
        run_prog(10);
        chk_w(8'h01);
        chk("far target fetched", 32'h1, {31'h0, hit_top});
        // reset in mid-run: the core halts and fetch restarts at zero
        apb(1'b1, `CBIE_OFF_CTRL, 32'h1);
        repeat (6) @(posedge core_clk);
        rst <= 1'b1;
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        chk("prog_addr after second reset", 32'h0, {11'h0, prog_addr});
        apb(1'b0, `CBIE_OFF_CTRL, 32'h0);
        chk("run after second reset", 32'h0, rd);
        test_done();
    end

    initial begin
        repeat (20000) @(posedge core_clk);
        n_fail++;
        test_done();
    end
endmodule
`default_nettype wire
